//--- dv/tb_top.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import usc_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  usc_sfr_req_t req = '0;
  logic baud_tick = 1'b0;
  logic [7:0] sfr_rdata;
  logic rxd_drv, rxd_oe, txd, tx_irq, rx_irq, peer_rxd, rxd_wire;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] fifo_exp[$];
  logic [7:0] d;
  logic [10:0] cap;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 32'hb27a6c9a;
  int wait_n;

  // ----------------------------------------
  // Clock, baud source, pins
  // ----------------------------------------
  always #50 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) baud_tick <= #1 ~baud_tick;
  assign rxd_wire = rxd_oe ? rxd_drv : peer_rxd;

  usc_serial_control usc_serial_control_inst (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .sfr_req_in(req),
    .sfr_rdata_out(sfr_rdata),
    .baud_tick_in(baud_tick),
    .rxd_in(rxd_wire),
    .rxd_out(rxd_drv),
    .rxd_oe_out(rxd_oe),
    .txd_out(txd),
    .tx_irq_out(tx_irq),
    .rx_irq_out(rx_irq)
  );

  usc_peer usc_peer_inst (
    .clk_in(core_clk_in),
    .txd_in(txd),
    .rxd_out(peer_rxd)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: v};
    cyc(1);
    req = '0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    cyc(1);
    req = '0;
    cyc(1);
  endtask

  task automatic wait_flag(input logic tx_side, input int limit);
    wait_n = 0;
    while (((tx_side ? tx_irq : rx_irq) !== 1'b1) && wait_n < limit)
    begin
      cyc(1);
      wait_n++;
    end
  endtask

  task automatic frame(input logic [7:0] v, input logic nin, input logic stop, input int n);
    usc_peer_inst.send((n == 10) ? {1'b1, stop, v, 1'b0} : {stop, nin, v, 1'b0}, n);
    cyc(40);
  endtask

  // ----------------------------------------
  // Read monitor
  // ----------------------------------------
  always @(posedge core_clk_in) rd_q <= req.rd;
  always @(negedge core_clk_in)
  begin
    if (rd_q)
      check(sfr_rdata, exp_q.pop_front());
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    cyc(2);
    rst_in = 1'b0;
    cyc(1);
    rd(CTRL_ADDR_U1, CTRL_RESET);
    rd(8'h42, READ_IDLE);
    for (int m = 0; m < 4; m++)
    begin
      wr(CTRL_ADDR_U1, {m[1:0], 6'h08});
      rd(CTRL_ADDR_U1, {m[1:0], 6'h08});
    end
    wr(CTRL_ADDR_U1, 8'h50);
    frame(8'ha5, 1'b0, 1'b1, 10);
    check({7'h00, rx_irq}, 8'h01);
    rd(CTRL_ADDR_U1, 8'h55);
    rd(DATA_ADDR_U1, 8'ha5);
    wr(CTRL_ADDR_U1, 8'h50);
    rd(CTRL_ADDR_U1, 8'h50);
    wr(CTRL_ADDR_U1, 8'h70);
    frame(8'h3c, 1'b0, 1'b0, 10);
    check({7'h00, rx_irq}, 8'h00);
    frame(8'h3d, 1'b0, 1'b1, 10);
    check({7'h00, rx_irq}, 8'h01);
    rd(DATA_ADDR_U1, 8'h3d);
    wr(CTRL_ADDR_U1, 8'hf0);
    frame(8'h11, 1'b0, 1'b1, 11);
    check({7'h00, rx_irq}, 8'h00);
    frame(8'h12, 1'b1, 1'b1, 11);
    rd(CTRL_ADDR_U1, 8'hf5);
    rd(DATA_ADDR_U1, 8'h12);
    wr(CTRL_ADDR_U1, 8'hd0);
    frame(8'h13, 1'b0, 1'b1, 11);
    rd(CTRL_ADDR_U1, 8'hd1);
    rd(DATA_ADDR_U1, 8'h13);
    wr(CTRL_ADDR_U1, 8'h40);
    frame(8'h77, 1'b0, 1'b1, 10);
    check({7'h00, rx_irq}, 8'h00);
    rd(DATA_ADDR_U1, READ_IDLE);
    wr(CTRL_ADDR_U1, 8'h50);
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      d = 8'($random(seed));
      if (i < FIFO_DEPTH)
        fifo_exp.push_back(d);
      frame(d, 1'b0, 1'b1, 10);
    end
    for (int i = 0; i < FIFO_DEPTH; i++)
      rd(DATA_ADDR_U1, fifo_exp.pop_front());
    rd(DATA_ADDR_U1, READ_IDLE);
    wr(CTRL_ADDR_U1, 8'h88);
    fork
      usc_peer_inst.capture(cap, 11);
      begin
        wr(DATA_ADDR_U1, 8'h6c);
        wait_flag(1'b1, 400);
      end
    join
    check({7'h00, wait_n > 310 && wait_n < 340}, 8'h01);
    check(cap[8:1], 8'h6c);
    check({5'h00, cap[10:9], cap[0]}, 8'h06);
    cyc(300);
    check({7'h00, tx_irq}, 8'h01);
    wr(CTRL_ADDR_U1, 8'h80);
    cyc(2);
    check({7'h00, tx_irq}, 8'h00);
    wr(CTRL_ADDR_U1, 8'h00);
    fork
      repeat (8) @(posedge txd) cap = {rxd_wire, cap[10:1]};
      begin
        wr(DATA_ADDR_U1, 8'h5a);
        wait_flag(1'b1, 200);
      end
    join
    check({7'h00, wait_n > 84 && wait_n < 116}, 8'h01);
    check(cap[10:3], 8'h5a);
    wr(CTRL_ADDR_U1, 8'h10);
    wait_flag(1'b0, 200);
    check({7'h00, rx_irq}, 8'h01);
    rd(DATA_ADDR_U1, 8'hff);
    cyc(5);
    report_and_stop();
  end

  // Watchdog
  initial
  begin
    #(100 * 40000);
    miscompares++;
    report_and_stop();
  end
endmodule

`default_nettype wire

//--- dv/usc_peer.sv
// Serial peer model on the receive and transmit pins
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Peer device
// ----------------------------------------
module usc_peer #(
  parameter int BIT_CLKS = 32,
  parameter int STOP_CLKS = 24
) (
  // Clock
  input wire logic clk_in,
  // Serial pins seen from the peer
  input wire logic txd_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;

  // Sends n bits LSB first, short last bit, line idles high
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd_out = bits[i];
      repeat ((i == n - 1) ? STOP_CLKS : BIT_CLKS) @(posedge clk_in);
      #1;
    end
    rxd_out = 1'b1;
  endtask

  // Samples n bits mid-bit after a falling start edge
  task automatic capture(output logic [10:0] bits, input int n);
    bits = '1;
    @(negedge txd_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      bits[i] = txd_in;
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

//--- logic/usc_serial_control.sv
// Serial port control, status and frame engine with receive FIFO
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Receive FIFO
// ----------------------------------------
module usc_fifo #(
  parameter int WIDTH = usc_pkg::RX_WORD_W,
  parameter int DEPTH = usc_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;
  assign in_ready_out = count != CW'(DEPTH);
  assign out_valid_out = count != '0;
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// Operation
// - The two-bit mode field, high bit in bit 7, picks mode 0, 1, 2 or 3.
// - In mode 1 with multiprocessor enable set, a frame is flagged only if its stop bit is 1.
// - In modes 2 and 3 with multiprocessor enable set, only frames with ninth bit 1 are flagged.
// - In mode 0 the transmit flag sets at the end of the eighth bit time.
// - In modes 1 to 3 the transmit flag sets as the stop bit starts.
// - The transmit flag is never cleared by hardware, only by a control write.
// - Reset loads the control register with 00h.
// - Modes 2 and 3 send the ninth transmit bit and store the received ninth bit.
// - Mode 1 stores the eight data bits and puts the stop bit into the ninth receive bit.
// - A write to the data buffer starts a transmission in every mode.
// - Mode 0 receives when the receive flag is 0, enabled, the transmitter idle and the FIFO not full; others on a start bit with FIFO room.
module usc_serial_control #(
  parameter logic [7:0] CTRL_ADDR = usc_pkg::CTRL_ADDR_U1,
  parameter logic [7:0] DATA_ADDR = usc_pkg::DATA_ADDR_U1,
  parameter int DEPTH = usc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Special function register port
  input wire usc_pkg::usc_sfr_req_t sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  // Baud source for modes 1 and 3, sixteen ticks per bit
  input wire logic baud_tick_in,
  // Serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_out,
  output logic txd_out,
  // Flag levels to the interrupt logic
  output logic tx_irq_out,
  output logic rx_irq_out
);
  import usc_pkg::*;
  localparam logic [3:0] M2_LAST = 4'(MODE2_DIV / OS_RATE - 1);

  function automatic logic [3:0] frame_bits(input usc_mode_t m);
    unique case (m)
      USC_MODE0: frame_bits = BITS_M0;
      USC_MODE1: frame_bits = BITS_M1;
      USC_MODE2, USC_MODE3: frame_bits = BITS_M23;
    endcase
  endfunction

  usc_ctrl_t ctrl;
  usc_mode_t mode;
  usc_tx_state_t tx_state;
  usc_rx_state_t rx_state;
  usc_rx_word_t rx_word;
  usc_rx_word_t fifo_word;
  logic ctrl_wr, ctrl_rd, data_wr, data_rd;
  logic rxd_meta, rxd_s;
  logic [3:0] m0_cnt, m2_cnt;
  logic m0_end, os_tick, m0_restart;
  logic [10:0] tx_sh;
  logic [3:0] tx_left, tx_os;
  logic tx_bit_end, tx_set;
  logic [10:0] rx_sh, rx_full;
  logic [3:0] rx_left, rx_os;
  logic rx_sample, rx_done, rx_accept;
  logic start_sync, start_async;
  logic fifo_in_ready, fifo_out_valid;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign mode = usc_mode_t'({ctrl.mode_select_hi, ctrl.mode_select_lo});
  assign ctrl_wr = sfr_req_in.wr && sfr_req_in.addr == CTRL_ADDR;
  assign ctrl_rd = sfr_req_in.rd && sfr_req_in.addr == CTRL_ADDR;
  assign data_wr = sfr_req_in.wr && sfr_req_in.addr == DATA_ADDR;
  assign data_rd = sfr_req_in.rd && sfr_req_in.addr == DATA_ADDR;

  // ----------------------------------------
  // Pin sync and bit timing
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rxd_meta <= 1'b1;
      rxd_s <= 1'b1;
    end
    else
    begin
      rxd_meta <= rxd_in;
      rxd_s <= rxd_meta;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      m0_cnt <= '0;
      m2_cnt <= '0;
    end
    else
    begin
      m0_cnt <= (m0_end || m0_restart) ? '0 : m0_cnt + 4'h1;
      m2_cnt <= (m2_cnt == M2_LAST) ? '0 : m2_cnt + 4'h1;
    end
  end
  assign m0_end = m0_cnt == M0_LAST;
  // Full first bit in mode 0
  assign m0_restart = data_wr || (rx_state == USC_RX_IDLE && start_sync);
  assign os_tick = (mode == USC_MODE2) ? (m2_cnt == M2_LAST) : baud_tick_in;

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  assign tx_bit_end = (mode == USC_MODE0) ? m0_end : (os_tick && tx_os == OS_LAST);
  assign tx_set = tx_state == USC_TX_BUSY && tx_bit_end &&
                  tx_left == ((mode == USC_MODE0) ? 4'h1 : 4'h2);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_state <= USC_TX_IDLE;
      tx_sh <= '1;
      tx_left <= '0;
      tx_os <= '0;
    end
    else if (data_wr)
    begin
      tx_state <= USC_TX_BUSY;
      tx_left <= frame_bits(mode);
      tx_os <= '0;
      if (mode == USC_MODE0)
      begin
        tx_sh <= {3'b111, sfr_req_in.wdata};
      end
      else
      begin
        tx_sh <= {1'b1, (mode == USC_MODE1) | ctrl.tx_ninth_bit, sfr_req_in.wdata, 1'b0};
      end
    end
    else
    begin
      unique case (tx_state)
        USC_TX_IDLE:
        begin
          tx_os <= '0;
        end
        USC_TX_BUSY:
        begin
          if (os_tick)
          begin
            tx_os <= tx_os + 4'h1;
          end
          if (tx_bit_end)
          begin
            tx_sh <= {1'b1, tx_sh[10:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1)
            begin
              tx_state <= USC_TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  assign start_sync = ctrl.rx_enable && mode == USC_MODE0 && !ctrl.rx_complete_flag &&
                      tx_state == USC_TX_IDLE && fifo_in_ready;
  assign start_async = ctrl.rx_enable && mode != USC_MODE0 && !rxd_s && fifo_in_ready;
  assign rx_sample = (rx_state == USC_RX_SYNC) ? m0_end :
                     (rx_state == USC_RX_ASYNC && os_tick && rx_os == OS_MID);
  assign rx_full = {rxd_s, rx_sh[10:1]};
  assign rx_done = rx_sample && rx_left == 4'h1 && ctrl.rx_enable;

  always_comb
  begin
    unique case (mode)
      USC_MODE0: rx_word = {ctrl.rx_ninth_bit, rx_full[10:3]};
      USC_MODE1: rx_word = {rx_full[10], rx_full[9:2]};
      USC_MODE2, USC_MODE3: rx_word = {rx_full[9], rx_full[8:1]};
    endcase
  end
  assign rx_accept = rx_done && (mode == USC_MODE0 || !ctrl.multiproc_enable ||
                     rx_word.ninth);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_state <= USC_RX_IDLE;
      rx_sh <= '1;
      rx_left <= '0;
      rx_os <= '0;
    end
    else if (!ctrl.rx_enable)
    begin
      rx_state <= USC_RX_IDLE;
    end
    else
    begin
      case (rx_state)
        USC_RX_IDLE:
        begin
          rx_os <= '0;
          if (start_sync)
          begin
            rx_state <= USC_RX_SYNC;
            rx_left <= BITS_M0;
          end
          else if (start_async)
          begin
            rx_state <= USC_RX_ASYNC;
            rx_left <= frame_bits(mode);
          end
        end
        USC_RX_SYNC, USC_RX_ASYNC:
        begin
          if (os_tick)
          begin
            rx_os <= rx_os + 4'h1;
          end
          if (rx_sample)
          begin
            rx_sh <= rx_full;
            rx_left <= rx_left - 4'h1;
            if (rx_left == 4'h1 || (rx_state == USC_RX_ASYNC &&
                rx_left == frame_bits(mode) && rxd_s))
            begin
              rx_state <= USC_RX_IDLE;
            end
          end
        end
        default:
        begin
          rx_state <= USC_RX_IDLE;
        end
      endcase
    end
  end

  usc_fifo #(
    .WIDTH(RX_WORD_W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .clk_in(core_clk_in),
    .rst_in(rst_in),
    .in_valid_in(rx_accept),
    .in_ready_out(fifo_in_ready),
    .in_data_in(rx_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(data_rd),
    .out_data_out(fifo_word)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl <= usc_ctrl_t'(CTRL_RESET);
    end
    else
    begin
      if (ctrl_wr)
      begin
        ctrl <= usc_ctrl_t'(sfr_req_in.wdata);
      end
      if (rx_accept)
      begin
        ctrl.rx_ninth_bit <= rx_word.ninth;
        ctrl.rx_complete_flag <= 1'b1;
      end
      if (tx_set)
      begin
        ctrl.tx_complete_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sfr_rdata_out <= READ_IDLE;
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_out <= 1'b0;
      tx_irq_out <= 1'b0;
      rx_irq_out <= 1'b0;
    end
    else
    begin
      if (data_rd && fifo_out_valid)
      begin
        sfr_rdata_out <= fifo_word.data;
      end
      else if (ctrl_rd)
      begin
        sfr_rdata_out <= ctrl;
      end
      else
      begin
        sfr_rdata_out <= READ_IDLE;
      end
      if (mode == USC_MODE0 && (tx_state == USC_TX_BUSY || rx_state == USC_RX_SYNC))
      begin
        txd_out <= m0_cnt >= M0_LOW;
      end
      else
      begin
        txd_out <= (tx_state == USC_TX_BUSY) ? tx_sh[0] : 1'b1;
      end
      rxd_out <= tx_sh[0];
      rxd_oe_out <= tx_state == USC_TX_BUSY && mode == USC_MODE0;
      tx_irq_out <= ctrl.tx_complete_flag;
      rx_irq_out <= ctrl.rx_complete_flag;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence stop_bit_start_s;
    tx_state == USC_TX_BUSY && mode != USC_MODE0 && tx_bit_end && tx_left == 4'h2;
  endsequence
  sequence frame_taken_s;
    rx_accept ##1 ctrl.rx_complete_flag;
  endsequence

  mode_decode_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ctrl_wr && !rx_accept |=> mode == usc_mode_t'($past(sfr_req_in.wdata[7:6])))
    else $error("mode does not follow written field");
  stop_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rx_done && mode == USC_MODE1 && ctrl.multiproc_enable && !rx_full[10] |-> !rx_accept)
    else $error("mode 1 frame accepted with bad stop bit");
  ninth_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rx_done && mode[1] && (!ctrl.multiproc_enable || rx_full[9]) |-> rx_accept)
    else $error("mode 2/3 frame wrongly dropped");
  rx_enable_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !ctrl.rx_enable |=> rx_state == USC_RX_IDLE)
    else $error("receiver active while disabled");
  m0_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    tx_state == USC_TX_BUSY && mode == USC_MODE0 && m0_end && tx_left == 4'h1
    |=> ctrl.tx_complete_flag && tx_state == USC_TX_IDLE)
    else $error("mode 0 transmit flag late");
  stop_flag_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    stop_bit_start_s |=> ctrl.tx_complete_flag && tx_left == 4'h1)
    else $error("transmit flag not set at stop bit");
  flag_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ctrl.tx_complete_flag && !ctrl_wr |=> ctrl.tx_complete_flag)
    else $error("transmit flag cleared by hardware");
  reset_value_a: assert property (@(posedge core_clk_in)
    $past(rst_in) && !rst_in |-> ctrl == usc_ctrl_t'(CTRL_RESET))
    else $error("control register not reset");
  ninth_tx_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    data_wr && mode[1] |=> tx_sh[9] == $past(ctrl.tx_ninth_bit) && !tx_sh[0])
    else $error("ninth transmit bit not loaded");
  tx_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    data_wr |=> tx_state == USC_TX_BUSY && tx_left == frame_bits($past(mode)))
    else $error("data write did not start transmit");
  rx_store_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rx_accept |-> frame_taken_s ##0 ctrl.rx_ninth_bit == $past(rx_word.ninth))
    else $error("accepted frame not stored");
  sync_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    rx_state == USC_RX_IDLE && start_sync |=> rx_state == USC_RX_SYNC && rx_left == BITS_M0)
    else $error("mode 0 reception did not start");
endmodule

`default_nettype wire

//--- pkg/usc_pkg.sv
// Shared constants and types of the serial port control block
package usc_pkg;
  localparam logic [7:0] CTRL_ADDR_U1 = 8'hd8;
  localparam logic [7:0] DATA_ADDR_U1 = 8'hd9;
  localparam logic [7:0] CTRL_ADDR_U0 = 8'h98;
  localparam logic [7:0] DATA_ADDR_U0 = 8'h99;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [3:0] M0_LAST = 4'hb;
  localparam logic [3:0] M0_LOW = 4'h6;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam int MODE2_DIV = 32;
  localparam int OS_RATE = 16;
  localparam logic [3:0] BITS_M0 = 4'h8;
  localparam logic [3:0] BITS_M1 = 4'ha;
  localparam logic [3:0] BITS_M23 = 4'hb;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_WORD_W = 9;
  typedef enum logic [1:0] {
    USC_MODE0 = 2'b00,
    USC_MODE1 = 2'b01,
    USC_MODE2 = 2'b10,
    USC_MODE3 = 2'b11
  } usc_mode_t;
  typedef enum logic {
    USC_TX_IDLE = 1'b0,
    USC_TX_BUSY = 1'b1
  } usc_tx_state_t;
  typedef enum logic [1:0] {
    USC_RX_IDLE = 2'b00,
    USC_RX_SYNC = 2'b01,
    USC_RX_ASYNC = 2'b10
  } usc_rx_state_t;
  typedef struct packed {
    logic mode_select_hi;
    logic mode_select_lo;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_complete_flag;
    logic rx_complete_flag;
  } usc_ctrl_t;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } usc_sfr_req_t;
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } usc_rx_word_t;
endpackage
